// File: bench/fws_flash_model.sv
`timescale 1ns/1ps
`include "fws_defines.svh"
module fws_flash_model
    import fws_pkg::*;
(
    // Host side
    input wire fws_pins_s pins_in,
    input wire logic [15:0] dq_in,
    input wire logic host_drv_in,
    // Bench control
    input wire logic go_in,
    input wire logic [2:0] mode_in,
    input wire logic [7:0] reads_in,
    input wire logic [15:0] data_in,
    // Device side
    output logic [15:0] dq_out,
    output logic dq_drv_out,
    output logic rb_low_out,
    output logic [15:0] last_wr_out
);
    // Modes: 0 array, 1 program, 2 erase, 3 erase suspend, 4 stuck failed
    // Reads count 0 means the operation never ends by itself
    logic [2:0] mode_q = 3'h0;
    logic [7:0] left_q = 8'h00;
    logic [15:0] arr_q = 16'h0000;
    logic tog_q = 1'b0;
    logic stog_q = 1'b0;
    logic run;
    logic sect;
    assign run = (mode_q == 3'd1) || (mode_q == 3'd2) || (mode_q == 3'd4);
    assign sect = pins_in.addr[18:12] == 7'h12;
    assign dq_drv_out = !pins_in.ce_n && !pins_in.oe_n;
    assign rb_low_out = run;
    always @(posedge go_in or posedge pins_in.oe_n or posedge pins_in.we_n) begin
        if (go_in) begin
            mode_q = mode_in;
            left_q = reads_in;
            arr_q = data_in;
        end else if (host_drv_in) begin
            last_wr_out = dq_in;
            if (dq_in == `FWS_CMD_RESET) mode_q = 3'd0;
        end else if (!pins_in.ce_n) begin
            if (run) tog_q = ~tog_q;
            if (sect && (mode_q == 3'd2 || mode_q == 3'd3)) stog_q = ~stog_q;
            // Counted reads stand in for the timed revert of a protected target
            if (left_q == 8'd1 && mode_q != 3'd4) mode_q = 3'd0;
            if (left_q != 8'd0) left_q = left_q - 8'd1;
        end
    end
    always_comb begin
        case (mode_q)
            3'd1: dq_out = {8'h00, ~arr_q[7], tog_q, 6'h00};
            3'd2: dq_out = {8'h00, 1'b0, tog_q, 3'h0, stog_q, 2'h0};
            3'd3: dq_out = sect ? {8'h00, 1'b1, tog_q, 3'h0, stog_q, 2'h0} : arr_q;
            3'd4: dq_out = {8'h00, ~arr_q[7], tog_q, 1'b1, 5'h00};
            default: dq_out = arr_q;
        endcase
    end
endmodule // fws_flash_model

// File: bench/fws_status_host_assertions.sv
`timescale 1ns/1ps
module fws_status_host_assertions
    import fws_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Flash pins
    input wire fws_pins_s pins_out,
    input wire logic dq_oe_out
);
    // ****
    // Helper: cycles with output enable low
    // ****
    logic [4:0] oe_cnt_q;
    always_ff @(posedge ref_clk_in) begin
        oe_cnt_q <= (srst_in || pins_out.oe_n) ? 5'h00 : oe_cnt_q + 5'h01;
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    // ****
    // Properties
    // ****
    property p_pready_pulse; pready_out |=> !pready_out; endproperty
    property p_pready_access; pready_out |-> psel_in && penable_in; endproperty
    property p_err_ready; pslverr_out |-> pready_out; endproperty
    property p_zero_wait; psel_in && !penable_in |=> pready_out; endproperty
    property p_oe_excl; !pins_out.oe_n |-> pins_out.we_n && !pins_out.ce_n; endproperty
    property p_oe_setup; $fell(pins_out.oe_n) |-> $past(pins_out.ce_n, 2) == 1'b0; endproperty
    // Reset may cut a read short, so the first edge after it is not judged
    property p_oe_width;
        $rose(pins_out.oe_n) && !$past(srst_in) |-> oe_cnt_q == 5'd10;
    endproperty
    property p_we_width; $fell(pins_out.we_n) |-> !pins_out.we_n [*5] ##1 pins_out.we_n; endproperty
    property p_addr_hold;
        !pins_out.ce_n && !$past(pins_out.ce_n) |-> $stable(pins_out.addr);
    endproperty
    property p_ce_gap; $rose(pins_out.ce_n) |=> pins_out.ce_n; endproperty
    property p_dq_oe_read; dq_oe_out |-> pins_out.oe_n; endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
    a_pready_access: assert property (p_pready_access) else $error("pready outside access");
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    a_zero_wait: assert property (p_zero_wait) else $error("pready late");
    a_oe_excl: assert property (p_oe_excl) else $error("read strobe clash");
    a_oe_setup: assert property (p_oe_setup) else $error("read strobe setup short");
    a_oe_width: assert property (p_oe_width) else $error("read strobe width wrong");
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
    a_ce_gap: assert property (p_ce_gap) else $error("no idle gap between cycles");
    a_dq_oe_read: assert property (p_dq_oe_read) else $error("data driven during read");
    c_read: cover property ($rose(pins_out.oe_n));
    c_write: cover property ($rose(pins_out.we_n));
    c_err: cover property (pslverr_out);
endmodule // fws_status_host_assertions

bind fws_status_host fws_status_host_assertions u_chk (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .pins_out(pins_out),
    .dq_oe_out(dq_oe_out)
);

// File: bench/tb_top.sv
`timescale 1ns/1ps
`include "fws_defines.svh"
module tb_top;
    import fws_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, slv, h_oe, fl_drv, rb_low;
    fws_pins_s pins;
    logic [15:0] h_dq, fl_dq, dq_bus, last_wr;
    logic [15:0] dq_last = 16'h0000;
    logic go = 1'b0;
    logic [2:0] fl_mode = 3'h0;
    logic [7:0] fl_reads = 8'h00;
    logic [15:0] fl_data = 16'h0000;
    int err_total = 0;
    int samples_checked = 0;
    // Undriven data lines show a changing pattern, never a stale word
    assign dq_bus = h_oe ? h_dq : (fl_drv ? fl_dq : ~dq_last);
    always @(posedge clk) dq_last <= dq_bus;
    initial forever #4 clk = ~clk;
    fws_status_host dut (
        .ref_clk_in(clk), .srst_in(srst), .ce_in(1'b1), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .dq_in(dq_bus), .ready_busy_n_in(~rb_low),
        .pins_out(pins), .dq_out(h_dq), .dq_oe_out(h_oe)
    );
    fws_flash_model u_flash (
        .pins_in(pins), .dq_in(dq_bus), .host_drv_in(h_oe), .go_in(go), .mode_in(fl_mode),
        .reads_in(fl_reads), .data_in(fl_data), .dq_out(fl_dq), .dq_drv_out(fl_drv),
        .rb_low_out(rb_low), .last_wr_out(last_wr)
    );
    // ****
    // Tasks
    // ****
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t ns: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            err_total++;
            results();
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        apb(1'b0, `FWS_OFF_STATUS, 32'h0);
        while (rd[1] !== 1'b1 && n < 3000) begin
            apb(1'b0, `FWS_OFF_STATUS, 32'h0);
            n++;
        end
        if (n >= 3000) begin
            err_total++;
            results();
        end
    endtask
    // Mode is settled a cycle before the start pulse reaches the model
    task automatic fl_set(input logic [2:0] m, input logic [7:0] n, input logic [15:0] d);
        fl_mode <= m;
        fl_reads <= n;
        fl_data <= d;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
    endtask
    task automatic op_run(input logic [18:0] a, input logic [15:0] wd, input logic [2:0] op);
        apb(1'b1, `FWS_OFF_ADDR, {13'h0, a});
        apb(1'b1, `FWS_OFF_WDATA, {16'h0, wd});
        apb(1'b1, `FWS_OFF_CTRL, {28'h0, 1'b1, op});
        wait_done();
    endtask
    task automatic st_check(input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, `FWS_OFF_STATUS, 32'h0);
        check(rd & mask, exp);
    endtask
    // ****
    // Scenarios
    // ****
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        st_check(32'hffffffff, 32'h8);
        apb(1'b0, 12'h014, 32'h0);
        check({rd[30:0], slv}, 32'h1);
        $display("test reset finished");
        for (int op = 3; op <= 4; op++) begin
            fl_set(3'd1, 8'd3, 16'h0083);
            op_run(19'h12345, 16'h0083, 3'(op));
            check(rd, 32'ha);
            apb(1'b0, `FWS_OFF_RDATA, 32'h0);
            check(rd, 32'h83);
            $display("test program poll %0d finished", op);
        end
        fl_set(3'd2, 8'd4, 16'hffff);
        op_run(19'h12000, 16'h0080, 3'd3);
        check(rd & 32'h7, 32'h2);
        apb(1'b0, `FWS_OFF_RDATA, 32'h0);
        check(rd, 32'hffff);
        fl_set(3'd3, 8'd0, 16'h0000);
        op_run(19'h12010, 16'h0080, 3'd4);
        check(rd & 32'h27, 32'h22);
        $display("test erase finished");
        op_run(19'h00555, 16'h00aa, 3'd1);
        check({16'h0, last_wr}, 32'haa);
        fl_set(3'd0, 8'd0, 16'hbeef);
        op_run(19'h00555, 16'h0000, 3'd2);
        apb(1'b0, `FWS_OFF_RDATA, 32'h0);
        check(rd, 32'hbeef);
        apb(1'b0, `FWS_OFF_CTRL, 32'h0);
        check(rd & 32'h7, 32'h2);
        apb(1'b1, `FWS_OFF_CTRL, 32'h8);
        st_check(32'h7, 32'h2);
        $display("test single cycles finished");
        for (int op = 3; op <= 4; op++) begin
            fl_set(3'd4, 8'd0, 16'h0080);
            op_run(19'h00100, 16'h0080, 3'(op));
            check(rd & 32'h17, 32'h16);
            check({16'h0, last_wr}, 32'hf0);
            st_check(32'h9, 32'h8);
            $display("test failure %0d finished", op);
        end
        fl_set(3'd1, 8'd0, 16'h0001);
        apb(1'b1, `FWS_OFF_CTRL, 32'hd);
        repeat (20) @(posedge clk);
        st_check(32'hb, 32'h1);
        fl_set(3'd0, 8'd0, 16'h0001);
        wait_done();
        check(rd & 32'hb, 32'ha);
        $display("test ready wait finished");
        fl_set(3'd1, 8'd0, 16'h0080);
        apb(1'b1, `FWS_OFF_CTRL, 32'hb);
        repeat (40) @(posedge clk);
        apb(1'b1, `FWS_OFF_CTRL, 32'h10);
        repeat (40) @(posedge clk);
        st_check(32'h3, 32'h0);
        $display("test abort finished");
        results();
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        results();
    end
endmodule // tb_top

// File: src/fws_bus_cycle.sv
`timescale 1ns/1ps
`include "fws_defines.svh"
module fws_bus_cycle
    import fws_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // Request
    input wire logic req_in,
    input wire logic wr_in,
    input wire logic [`FWS_AW-1:0] addr_in,
    input wire logic [`FWS_DW-1:0] wdata_in,
    output logic [`FWS_DW-1:0] rdata_out,
    output logic done_out,
    // Flash pins
    input wire logic [`FWS_DW-1:0] dq_in,
    output fws_pins_s pins_out,
    output logic [`FWS_DW-1:0] dq_out,
    output logic dq_oe_out
);
    fws_bus_st_e st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic wr_q, wr_d;
    fws_pins_s pins_d;
    logic [`FWS_DW-1:0] dq_d, rdata_d;
    logic dq_oe_d, done_d;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q - 4'h1;
        wr_d = wr_q;
        pins_d = pins_out;
        dq_d = dq_out;
        dq_oe_d = dq_oe_out;
        rdata_d = rdata_out;
        done_d = 1'b0;
        case (st_q)
            B_IDLE: begin
                cnt_d = cnt_q;
                if (req_in) begin
                    pins_d.ce_n = 1'b0;
                    pins_d.addr = addr_in;
                    dq_d = wdata_in;
                    dq_oe_d = wr_in;
                    wr_d = wr_in;
                    cnt_d = `FWS_SU_CYC;
                    st_d = B_SETUP;
                end
            end
            B_SETUP: begin
                if (cnt_q == 4'h1) begin
                    st_d = B_STROBE;
                    cnt_d = wr_q ? `FWS_WP_CYC : `FWS_RD_CYC;
                    pins_d.we_n = !wr_q;
                    pins_d.oe_n = wr_q;
                end
            end
            B_STROBE: begin
                if (cnt_q == 4'h1) begin
                    // Each read ends with a strobe rising, so the device sees a full cycle
                    if (!wr_q) begin
                        rdata_d = dq_in;
                    end
                    pins_d.we_n = 1'b1;
                    pins_d.oe_n = 1'b1;
                    cnt_d = `FWS_HLD_CYC;
                    st_d = B_HOLD;
                end
            end
            B_HOLD: begin
                if (cnt_q == 4'h1) begin
                    pins_d.ce_n = 1'b1;
                    dq_oe_d = 1'b0;
                    done_d = 1'b1;
                    st_d = B_IDLE;
                end
            end
            default: st_d = B_IDLE;
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            st_q <= B_IDLE;
            cnt_q <= 4'h0;
            wr_q <= 1'b0;
            pins_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
            dq_out <= '0;
            dq_oe_out <= 1'b0;
            rdata_out <= '0;
            done_out <= 1'b0;
        end else if (ce_in) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            wr_q <= wr_d;
            pins_out <= pins_d;
            dq_out <= dq_d;
            dq_oe_out <= dq_oe_d;
            rdata_out <= rdata_d;
            done_out <= done_d;
        end
    end
endmodule // fws_bus_cycle

// File: src/fws_defines.svh
`ifndef FWS_DEFINES_SVH
`define FWS_DEFINES_SVH

// ****************************************
// Widths
// ****************************************
`define FWS_AW 19
`define FWS_DW 16
`define FWS_PAW 12

// ****************************************
// Register map
// ****************************************
`define FWS_OFF_CTRL 12'h000
`define FWS_OFF_ADDR 12'h004
`define FWS_OFF_WDATA 12'h008
`define FWS_OFF_RDATA 12'h00c
`define FWS_OFF_STATUS 12'h010
`define FWS_CTRL_OP_HI 2
`define FWS_CTRL_START 3
`define FWS_CTRL_ABORT 4
`define FWS_ST_BUSY 0
`define FWS_ST_DONE 1
`define FWS_ST_FAIL 2
`define FWS_ST_READY 3
`define FWS_ST_TMO 4
`define FWS_ST_SECT 5

// ****************************************
// Status bits on the data lines
// ****************************************
`define FWS_DQ_POLL 7
`define FWS_DQ_TOGGLE 6
`define FWS_DQ_FAIL 5
`define FWS_DQ_SECTOR 2
`define FWS_CMD_RESET 16'h00f0
`define FWS_RESET_ADDR 19'h00000

// ****************************************
// Bus cycle timing
// ****************************************
`define FWS_CLK_NS 8
`define FWS_T_SU_NS 16
`define FWS_T_RD_NS 80
`define FWS_T_WP_NS 40
`define FWS_T_HLD_NS 24
`define FWS_CYC(ns) (((ns) + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_SU_CYC 4'(`FWS_CYC(`FWS_T_SU_NS))
`define FWS_RD_CYC 4'(`FWS_CYC(`FWS_T_RD_NS))
`define FWS_WP_CYC 4'(`FWS_CYC(`FWS_T_WP_NS))
`define FWS_HLD_CYC 4'(`FWS_CYC(`FWS_T_HLD_NS))

`endif

// File: src/fws_pkg.sv
`include "fws_defines.svh"
package fws_pkg;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        OP_NOP, OP_WRITE, OP_READ, OP_DPOLL, OP_TPOLL, OP_RBWAIT
    } fws_op_e;

    typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} fws_bus_st_e;

    typedef enum logic [1:0] {S_IDLE, S_CYCLE, S_RESET, S_RBWAIT} fws_seq_st_e;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [`FWS_AW-1:0] addr;
    } fws_pins_s;
endpackage

// File: src/fws_status_host.sv
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fws_defines.svh"
module fws_status_host
    import fws_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [`FWS_PAW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Flash device
    input wire logic [`FWS_DW-1:0] dq_in,
    input wire logic ready_busy_n_in,
    output fws_pins_s pins_out,
    output logic [`FWS_DW-1:0] dq_out,
    output logic dq_oe_out
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic reg_hit(input logic [`FWS_PAW-1:0] a);
        reg_hit = (a == `FWS_OFF_CTRL) || (a == `FWS_OFF_ADDR) || (a == `FWS_OFF_WDATA) ||
                  (a == `FWS_OFF_RDATA) || (a == `FWS_OFF_STATUS);
    endfunction

    function automatic logic flip(input logic [`FWS_DW-1:0] a, input logic [`FWS_DW-1:0] b,
                                  input int idx);
        flip = a[idx] ^ b[idx];
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic pready_d, pslverr_d;
    logic [31:0] prdata_d;
    logic [`FWS_AW-1:0] addr_q, addr_d;
    logic [`FWS_DW-1:0] wdata_q, wdata_d;
    fws_seq_st_e st_q, st_d;
    fws_op_e op_q, op_d;
    logic [2:0] step_q, step_d;
    logic [`FWS_DW-1:0] prev_q, prev_d, rdata_q, rdata_d;
    logic issue_q, issue_d, iss_wr_q, iss_wr_d;
    logic done_q, done_d, fail_q, fail_d, tmo_q, tmo_d;
    logic sect_q, sect_d, abort_q, abort_d, rb_q;
    logic wr_acc, start, abort_req, bus_done, exp7;
    logic [`FWS_DW-1:0] r;
    logic [31:0] stat_w;
    fws_op_e new_op;

    assign wr_acc = psel_in && penable_in && pwrite_in && pready_out && reg_hit(paddr_in);
    assign start = wr_acc && (paddr_in == `FWS_OFF_CTRL) && pwdata_in[`FWS_CTRL_START];
    assign abort_req = wr_acc && (paddr_in == `FWS_OFF_CTRL) && pwdata_in[`FWS_CTRL_ABORT];
    assign new_op = fws_op_e'(pwdata_in[`FWS_CTRL_OP_HI:0]);
    // Software loads bit 7 of WDATA: program data for a program, 1 for an erase
    assign exp7 = wdata_q[`FWS_DQ_POLL];

    always_comb begin
        stat_w = 32'h0;
        stat_w[`FWS_ST_BUSY] = (st_q != S_IDLE);
        stat_w[`FWS_ST_DONE] = done_q;
        stat_w[`FWS_ST_FAIL] = fail_q;
        stat_w[`FWS_ST_READY] = rb_q;
        stat_w[`FWS_ST_TMO] = tmo_q;
        stat_w[`FWS_ST_SECT] = sect_q;
    end

    // ****************************************
    // APB slave
    // ****************************************
    // Reply is prepared in the setup cycle so the outputs stay flop-driven;
    // status read therefore reflects the setup cycle.
    always_comb begin
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = 32'h0;
        addr_d = addr_q;
        wdata_d = wdata_q;
        if (psel_in && !penable_in) begin
            pready_d = 1'b1;
            pslverr_d = !reg_hit(paddr_in);
            if (!pwrite_in) begin
                case (paddr_in)
                    `FWS_OFF_CTRL: prdata_d = {29'h0, op_q};
                    `FWS_OFF_ADDR: prdata_d = {13'h0, addr_q};
                    `FWS_OFF_WDATA: prdata_d = {16'h0, wdata_q};
                    `FWS_OFF_RDATA: prdata_d = {16'h0, rdata_q};
                    `FWS_OFF_STATUS: prdata_d = stat_w;
                    default: prdata_d = 32'h0;
                endcase
            end
        end
        if (wr_acc && paddr_in == `FWS_OFF_ADDR) begin
            addr_d = pwdata_in[`FWS_AW-1:0];
        end
        if (wr_acc && paddr_in == `FWS_OFF_WDATA) begin
            wdata_d = pwdata_in[`FWS_DW-1:0];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
            addr_q <= '0;
            wdata_q <= '0;
        end else if (ce_in) begin
            pready_out <= pready_d;
            pslverr_out <= pslverr_d;
            prdata_out <= prdata_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
        end
    end

    // ****************************************
    // Status sequencer
    // ****************************************
    always_comb begin
        st_d = st_q;
        op_d = op_q;
        step_d = step_q;
        prev_d = prev_q;
        rdata_d = rdata_q;
        issue_d = 1'b0;
        iss_wr_d = iss_wr_q;
        done_d = done_q;
        fail_d = fail_q;
        tmo_d = tmo_q;
        sect_d = sect_q;
        abort_d = abort_q || abort_req;
        case (st_q)
            S_IDLE: begin
                if (start) begin
                    op_d = new_op;
                    step_d = 3'h0;
                    done_d = 1'b0;
                    fail_d = 1'b0;
                    tmo_d = 1'b0;
                    sect_d = 1'b0;
                    // Set wins: an abort in the same write as start still stops the poll
                    abort_d = abort_req;
                    case (new_op)
                        OP_WRITE, OP_READ, OP_DPOLL, OP_TPOLL: begin
                            issue_d = 1'b1;
                            iss_wr_d = (new_op == OP_WRITE);
                            st_d = S_CYCLE;
                        end
                        OP_RBWAIT: st_d = S_RBWAIT;
                        default: done_d = 1'b1;
                    endcase
                end
            end
            S_RBWAIT: begin
                // Line is open drain and may be shared; high means all ready
                if (rb_q) begin
                    done_d = 1'b1;
                    st_d = S_IDLE;
                end else if (abort_q) begin
                    st_d = S_IDLE;
                end
            end
            S_RESET: begin
                if (bus_done) begin
                    done_d = 1'b1;
                    st_d = S_IDLE;
                end
            end
            S_CYCLE: begin
                if (bus_done) begin
                    iss_wr_d = 1'b0;
                    issue_d = 1'b1;
                    case (op_q)
                        OP_DPOLL: begin
                            case (step_q)
                                3'h0: begin
                                    if (r[`FWS_DQ_POLL] == exp7) begin
                                        step_d = 3'h2;
                                    end else if (r[`FWS_DQ_FAIL]) begin
                                        tmo_d = 1'b1;
                                        step_d = 3'h1;
                                    end
                                end
                                3'h1: begin
                                    if (r[`FWS_DQ_POLL] == exp7) begin
                                        step_d = 3'h2;
                                    end else begin
                                        fail_d = 1'b1;
                                    end
                                end
                                default: begin
                                    rdata_d = r;
                                    done_d = 1'b1;
                                    issue_d = 1'b0;
                                    st_d = S_IDLE;
                                end
                            endcase
                        end
                        OP_TPOLL: begin
                            prev_d = r;
                            case (step_q)
                                3'h0: step_d = 3'h1;
                                3'h1: begin
                                    sect_d = sect_q || flip(r, prev_q, `FWS_DQ_SECTOR);
                                    if (!flip(r, prev_q, `FWS_DQ_TOGGLE)) begin
                                        step_d = 3'h4;
                                    end else if (r[`FWS_DQ_FAIL]) begin
                                        tmo_d = 1'b1;
                                        step_d = 3'h2;
                                    end else begin
                                        step_d = 3'h0;
                                    end
                                end
                                3'h2: begin
                                    if (!flip(r, prev_q, `FWS_DQ_TOGGLE)) begin
                                        step_d = 3'h4;
                                    end else begin
                                        fail_d = 1'b1;
                                    end
                                end
                                default: begin
                                    rdata_d = r;
                                    done_d = 1'b1;
                                    issue_d = 1'b0;
                                    st_d = S_IDLE;
                                end
                            endcase
                        end
                        default: begin
                            if (op_q == OP_READ) begin
                                rdata_d = r;
                            end
                            done_d = 1'b1;
                            issue_d = 1'b0;
                            st_d = S_IDLE;
                        end
                    endcase
                    if (fail_d && !fail_q) begin
                        iss_wr_d = 1'b1;
                        st_d = S_RESET;
                    end else if (abort_q && st_d == S_CYCLE) begin
                        // Abandoned poll restarts from the first step next time
                        issue_d = 1'b0;
                        st_d = S_IDLE;
                    end
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            st_q <= S_IDLE;
            op_q <= OP_NOP;
            step_q <= 3'h0;
            prev_q <= '0;
            rdata_q <= '0;
            issue_q <= 1'b0;
            iss_wr_q <= 1'b0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            tmo_q <= 1'b0;
            sect_q <= 1'b0;
            abort_q <= 1'b0;
            rb_q <= 1'b0;
        end else if (ce_in) begin
            st_q <= st_d;
            op_q <= op_d;
            step_q <= step_d;
            prev_q <= prev_d;
            rdata_q <= rdata_d;
            issue_q <= issue_d;
            iss_wr_q <= iss_wr_d;
            done_q <= done_d;
            fail_q <= fail_d;
            tmo_q <= tmo_d;
            sect_q <= sect_d;
            abort_q <= abort_d;
            rb_q <= ready_busy_n_in;
        end
    end

    // ****************************************
    // Flash bus cycles
    // ****************************************
    fws_bus_cycle u_cycle (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .req_in(issue_q),
        .wr_in(iss_wr_q),
        .addr_in(st_q == S_RESET ? `FWS_RESET_ADDR : addr_q),
        .wdata_in(st_q == S_RESET ? `FWS_CMD_RESET : wdata_q),
        .rdata_out(r),
        .done_out(bus_done),
        .dq_in(dq_in),
        .pins_out(pins_out),
        .dq_out(dq_out),
        .dq_oe_out(dq_oe_out)
    );
endmodule // fws_status_host
